// ---- rtl/dacc_consts.svh ----
// Timing and layout constants for the dual converter conversion control.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef DACC_CONSTS_SVH
`define DACC_CONSTS_SVH
`define DACC_CLK_PERIOD_NS      10
`define DACC_CONV_TIME_NS       800
`define DACC_CONV_CYCLES        (`DACC_CONV_TIME_NS / `DACC_CLK_PERIOD_NS)
`define DACC_ACQ_TIME_NS        250
`define DACC_ACQ_CYCLES         ((`DACC_ACQ_TIME_NS + `DACC_CLK_PERIOD_NS - 1) / `DACC_CLK_PERIOD_NS)
`define DACC_EOC_CYCLES         2
`define DACC_RESULT_BITS        16
`define DACC_FRAME_BITS         32
`define DACC_FIFO_WIDTH         32
`define DACC_FIFO_DEPTH         32
`define DACC_UPPER_LO           12
`define DACC_UPPER_HI           15
`define DACC_CNT_W              8
`define DACC_BIT_CNT_W          6
`define DACC_SYNC_STAGES        3
`endif

// ---- rtl/dacc_control.sv ----
// Conversion control and output port of a dual simultaneous-sampling converter.
// Assumes host pins are asynchronous; results come in from the analog core.
`timescale 1ns/1ns
`include "dacc_consts.svh"
module dacc_control (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Host pins
    input  wire logic        convert_start_n,
    input  wire logic        chip_select_n,
    input  wire logic        read_n,
    input  wire logic        device_reset,
    input  wire logic        power_down_request,
    input  wire logic        impulse_mode,
    input  wire logic        serial_parallel_select,
    input  wire logic        shift_clock_source_select,
    input  wire logic        ext_shift_clock,
    // Analog core results
    input  wire logic [15:0] result_a,
    input  wire logic [15:0] result_b,
    // Status outputs
    output logic             busy,
    output logic             end_of_convert_n,
    output logic             hold,
    output logic             low_power,
    output logic             read_error_flag,
    // Data pins, enable low while driving
    output logic [15:0]      data_out,
    output logic [15:0]      data_oe_n,
    output logic             serial_result_out
);
    logic [2:0] s_cnv, s_cs, s_rd, s_rst, s_pd, s_sck;
    dacc_pkg::dacc_state_t state;
    logic [`DACC_CNT_W-1:0]     timer;
    logic [`DACC_CNT_W-1:0]     eoc_timer;
    logic [`DACC_FRAME_BITS-1:0] shifter;
    logic [`DACC_BIT_CNT_W-1:0]  bit_cnt;
    logic        reading;
    logic        latch_pending;
    logic        cnv_fall, cnv_low, cs_low, rd_low, rst_hi, pd_hi, sck_rise;
    logic        out_en, slave_mode, frame_done;
    logic        fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [`DACC_FIFO_WIDTH-1:0] fifo_out;

    // Stable when the later two stages agree
    function automatic logic agreed(input logic [2:0] s, input logic prev);
        agreed = (s[2] == s[1]) ? s[1] : prev;
    endfunction

    // Three-stage pin synchronisers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_cnv <= 3'h7;
            s_cs  <= 3'h7;
            s_rd  <= 3'h7;
            s_rst <= 3'h0;
            s_pd  <= 3'h0;
            s_sck <= 3'h0;
        end else begin
            s_cnv <= {s_cnv[1:0], convert_start_n};
            s_cs  <= {s_cs[1:0], chip_select_n};
            s_rd  <= {s_rd[1:0], read_n};
            s_rst <= {s_rst[1:0], device_reset};
            s_pd  <= {s_pd[1:0], power_down_request};
            s_sck <= {s_sck[1:0], ext_shift_clock};
        end
    end

    // Filtered levels held once agreed
    logic cnv_q, cs_q, rd_q, rst_q, pd_q, sck_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnv_q <= 1'b1;
            cs_q  <= 1'b1;
            rd_q  <= 1'b1;
            rst_q <= 1'b0;
            pd_q  <= 1'b0;
            sck_q <= 1'b0;
        end else begin
            cnv_q <= agreed(s_cnv, cnv_q);
            cs_q  <= agreed(s_cs, cs_q);
            rd_q  <= agreed(s_rd, rd_q);
            rst_q <= agreed(s_rst, rst_q);
            pd_q  <= agreed(s_pd, pd_q);
            sck_q <= agreed(s_sck, sck_q);
        end
    end

    assign cnv_low   = !agreed(s_cnv, cnv_q);
    assign cnv_fall  = cnv_q && cnv_low;
    assign cs_low    = !cs_q;
    assign rd_low    = !rd_q;
    assign rst_hi    = rst_q;
    assign pd_hi     = pd_q;
    // External clock only counts while selected
    assign sck_rise  = !sck_q && agreed(s_sck, sck_q) && cs_low;
    assign slave_mode = serial_parallel_select && shift_clock_source_select;
    assign out_en    = cs_low && rd_low;
    assign frame_done = (bit_cnt == `DACC_BIT_CNT_W'(`DACC_FRAME_BITS - 1)) && sck_rise;

    // Conversion sequencer; power-down only blocks new starts
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= dacc_pkg::DACC_IDLE;
            timer <= '0;
        end else if (rst_hi) begin
            state <= dacc_pkg::DACC_IDLE;
            timer <= '0;
        end else begin
            case (state)
                dacc_pkg::DACC_IDLE: begin
                    if (!pd_hi && cnv_fall && !impulse_mode) begin
                        state <= dacc_pkg::DACC_CONV_A;
                        timer <= '0;
                    end else if (!pd_hi && impulse_mode && cnv_fall) begin
                        state <= dacc_pkg::DACC_CONV_A;
                        timer <= '0;
                    end
                end
                dacc_pkg::DACC_ACQ: begin
                    timer <= timer + `DACC_CNT_W'(1);
                    if (timer >= `DACC_CNT_W'(`DACC_ACQ_CYCLES - 1)) begin
                        if (impulse_mode && cnv_low && !pd_hi) begin
                            state <= dacc_pkg::DACC_CONV_A;
                            timer <= '0;
                        end else begin
                            state <= dacc_pkg::DACC_IDLE;
                        end
                    end
                end
                dacc_pkg::DACC_CONV_A, dacc_pkg::DACC_CONV_B: begin
                    timer <= timer + `DACC_CNT_W'(1);
                    if (timer == `DACC_CNT_W'(`DACC_CONV_CYCLES / 2 - 1)) begin
                        timer <= '0;
                        state <= (state == dacc_pkg::DACC_CONV_A) ? dacc_pkg::DACC_CONV_B
                                                                  : dacc_pkg::DACC_LATCH;
                    end
                end
                dacc_pkg::DACC_LATCH: begin
                    state <= dacc_pkg::DACC_ACQ;
                    timer <= '0;
                end
                default: state <= dacc_pkg::DACC_IDLE;
            endcase
        end
    end

    // Busy spans both channels until the word reaches the shifter
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            hold <= 1'b0;
            low_power <= 1'b0;
        end else begin
            busy <= !rst_hi && (state == dacc_pkg::DACC_CONV_A || state == dacc_pkg::DACC_CONV_B
                                || state == dacc_pkg::DACC_LATCH || latch_pending);
            hold <= !rst_hi && (state == dacc_pkg::DACC_CONV_A || state == dacc_pkg::DACC_CONV_B);
            low_power <= pd_hi && (state == dacc_pkg::DACC_IDLE);
        end
    end

    // One low pulse at the end of each channel
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            eoc_timer <= '0;
        end else if (rst_hi) begin
            eoc_timer <= '0;
        end else if ((state == dacc_pkg::DACC_CONV_A || state == dacc_pkg::DACC_CONV_B)
                     && timer == `DACC_CNT_W'(`DACC_CONV_CYCLES / 2 - 1)) begin
            eoc_timer <= `DACC_CNT_W'(`DACC_EOC_CYCLES);
        end else if (eoc_timer != '0) begin
            eoc_timer <= eoc_timer - `DACC_CNT_W'(1);
        end
    end
    assign end_of_convert_n = (eoc_timer == '0);

    // Results queued as one 32-bit word, channel A high
    dacc_fifo #(.WIDTH(`DACC_FIFO_WIDTH), .DEPTH(`DACC_FIFO_DEPTH)) u_fifo (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (state == dacc_pkg::DACC_LATCH),
        .in_ready  (fifo_in_ready),
        .in_data   ({result_a, result_b}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );
    // Newest word always taken; a partial read is lost to it
    assign fifo_pop = fifo_out_valid || !reading;

    // Word in flight from latch to shifter; busy covers it so its fall means data ready
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            latch_pending <= 1'b0;
        end else if (rst_hi) begin
            latch_pending <= 1'b0;
        end else if (state == dacc_pkg::DACC_LATCH) begin
            latch_pending <= 1'b1;
        end else if (fifo_out_valid && fifo_pop) begin
            latch_pending <= 1'b0;
        end
    end

    // Shift register and read tracking
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shifter <= '0;
            bit_cnt <= '0;
            reading <= 1'b0;
            read_error_flag <= 1'b0;
        end else begin
            read_error_flag <= 1'b0;
            if (rst_hi) begin
                reading <= 1'b0;
                bit_cnt <= '0;
            end else if (fifo_out_valid && fifo_pop) begin
                if (slave_mode && reading) begin
                    read_error_flag <= 1'b1;
                end
                shifter <= fifo_out;
                reading <= 1'b0;
                bit_cnt <= '0;
            end else if (serial_parallel_select && out_en && sck_rise) begin
                shifter <= {shifter[`DACC_FRAME_BITS-2:0], 1'b0};
                bit_cnt <= frame_done ? '0 : bit_cnt + `DACC_BIT_CNT_W'(1);
                reading <= !frame_done;
            end
        end
    end

    // Output pins, data from registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= '0;
            data_oe_n <= 16'hFFFF;
            serial_result_out <= 1'b0;
        end else begin
            data_out <= serial_parallel_select ? 16'h0000 : shifter[`DACC_FRAME_BITS-1 -: `DACC_RESULT_BITS];
            serial_result_out <= shifter[`DACC_FRAME_BITS-1];
            data_oe_n <= out_en ? 16'h0000 : 16'hFFFF;
            if (serial_parallel_select) begin
                data_oe_n[`DACC_UPPER_HI:`DACC_UPPER_LO] <= 4'hF;
            end
        end
    end

    // Reset aborts within two cycles of the filtered level
    busy_abort_a: assert property (@(posedge clock) disable iff (!reset_n)
        rst_hi |=> ##1 !busy) else $error("busy not cleared by reset");
    upper_float_a: assert property (@(posedge clock) disable iff (!reset_n)
        serial_parallel_select |=> data_oe_n[`DACC_UPPER_HI:`DACC_UPPER_LO] == 4'hF)
        else $error("upper bits driven");
    bus_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
        !out_en |=> data_oe_n[11:0] == 12'hFFF) else $error("bus driven unselected");
    error_mode_a: assert property (@(posedge clock) disable iff (!reset_n)
        read_error_flag |-> $past(slave_mode)) else $error("error flag outside slave");
    error_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        read_error_flag |=> !read_error_flag) else $error("error flag not a pulse");
    start_busy_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state == dacc_pkg::DACC_IDLE && cnv_fall && !pd_hi && !rst_hi) |=> ##1 busy)
        else $error("busy not raised on start");
    pd_block_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state == dacc_pkg::DACC_IDLE && pd_hi) |=> state != dacc_pkg::DACC_CONV_A)
        else $error("start while powered down");
    eoc_pair_a: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(end_of_convert_n) |-> busy || $past(busy)) else $error("eoc outside conversion");
    latch_busy_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state == dacc_pkg::DACC_LATCH) |=> busy) else $error("busy dropped at latch");
    busy_ready_a: assert property (@(posedge clock) disable iff (!reset_n)
        ($fell(busy) && !$past(rst_hi)) |-> !latch_pending && !fifo_out_valid) else $error("busy fell before load");
    queue_room_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state == dacc_pkg::DACC_LATCH) |-> fifo_in_ready) else $error("result queue full at latch");
    cover_conv_c: cover property (@(posedge clock) disable iff (!reset_n) $fell(busy));
    cover_err_c: cover property (@(posedge clock) disable iff (!reset_n) read_error_flag);
    cover_imp_c: cover property (@(posedge clock) disable iff (!reset_n)
        state == dacc_pkg::DACC_ACQ ##1 state == dacc_pkg::DACC_CONV_A);
endmodule

// ---- rtl/dacc_fifo.sv ----
// Result FIFO with parameterised width and depth; read data is registered.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`include "dacc_consts.svh"
module dacc_fifo #(
    parameter int WIDTH = `DACC_FIFO_WIDTH,
    parameter int DEPTH = `DACC_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Output register counts as one slot outside the array
    assign in_ready = (count != AW'(0) + (AW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = (!out_valid || out_ready) && (count != '0);

    // Array write
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered read port
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// ---- rtl/dacc_pkg.sv ----
// Types shared by the conversion control block.
// No assumptions beyond the constants header.
package dacc_pkg;
    typedef enum logic [2:0] {
        DACC_IDLE    = 3'b000,
        DACC_ACQ     = 3'b001,
        DACC_CONV_A  = 3'b010,
        DACC_CONV_B  = 3'b011,
        DACC_LATCH   = 3'b100
    } dacc_state_t;
endpackage

// ---- verification/dacc_control_tb_top.sv ----
// Bench for the conversion control block through its top, with a serial host model.
// Assumes 40-cycle channel conversions and a 25-cycle acquisition.
`timescale 1ns/1ns
module dacc_control_tb_top;
    logic        clock = 0, reset_n = 0, convert_start_n = 1, chip_select_n = 1, read_n = 1;
    logic        device_reset = 0, power_down_request = 0, impulse_mode = 0;
    logic        serial_parallel_select = 0, shift_clock_source_select = 0, ext_shift_clock;
    logic [15:0] result_a = 16'h0000, result_b = 16'h0000, data_out, data_oe_n;
    logic        busy, end_of_convert_n, hold, low_power, read_error_flag, serial_result_out;
    logic        eoc_q = 1;
    logic [31:0] word;
    int          n_errors = 0, num_checks = 0, eoc_cnt = 0, err_cnt = 0, n;

    dacc_control u_dacc_control (.clock(clock), .reset_n(reset_n), .convert_start_n(convert_start_n),
        .chip_select_n(chip_select_n), .read_n(read_n), .device_reset(device_reset),
        .power_down_request(power_down_request), .impulse_mode(impulse_mode),
        .serial_parallel_select(serial_parallel_select), .shift_clock_source_select(shift_clock_source_select),
        .ext_shift_clock(ext_shift_clock), .result_a(result_a), .result_b(result_b), .busy(busy),
        .end_of_convert_n(end_of_convert_n), .hold(hold), .low_power(low_power),
        .read_error_flag(read_error_flag), .data_out(data_out), .data_oe_n(data_oe_n),
        .serial_result_out(serial_result_out));
    dacc_host_model u_dacc_host_model (.ext_shift_clock(ext_shift_clock), .serial_result_out(serial_result_out));

    // 100 MHz system clock
    always #5 clock = ~clock;

    // Count end-of-convert falls and error pulses mid-cycle, away from the launching edge
    always @(negedge clock) begin
        if (eoc_q === 1'b1 && end_of_convert_n === 1'b0) eoc_cnt++;
        if (read_error_flag === 1'b1) err_cnt++;
        eoc_q <= end_of_convert_n;
    end

    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Bounded wait for busy; a hang ends the run
    task automatic wait_busy(input logic lvl, output int k);
        k = 0;
        while (busy !== lvl && k < 300) begin
            step(1);
            k++;
        end
        if (k >= 300) begin
            check("busy_wait", 1'b0, 1'b1);
            wrap_up();
        end
    endtask

    // Start strobe held long enough for the pin synchroniser
    task automatic kick();
        convert_start_n = 1'b0;
        step(4);
        convert_start_n = 1'b1;
    endtask

    // One full conversion; spacing afterwards covers the acquisition window
    task automatic convert(input logic [15:0] a, input logic [15:0] b);
        result_a = a;
        result_b = b;
        eoc_cnt = 0;
        kick();
        wait_busy(1'b1, n);
        check("hold", hold, 1'b1);
        wait_busy(1'b0, n);
        check("busy_long", (n >= 78), 1'b1);
        // Busy falling marks the new word as ready on the port
        if (!serial_parallel_select) begin
            check("ready_word", data_out, a);
        end
        step(3);
        check("eoc_count", eoc_cnt, 2);
        step(30);
    endtask

    initial begin
        step(2);
        reset_n = 1'b1;
        check("busy_rst", busy, 1'b0);
        check("oe_rst", data_oe_n, 16'hFFFF);
        convert(16'hA5C3, 16'h3C5A);
        // Parallel port: only both strobes low enable it
        for (int m = 0; m < 4; m++) begin
            {chip_select_n, read_n} = m[1:0];
            step(6);
            check("data_oe_n", data_oe_n, (m == 0) ? 16'h0000 : 16'hFFFF);
            if (m == 0) check("data_out", data_out, 16'hA5C3);
        end
        // Serial slave: upper bits float, clocks without select are ignored
        {serial_parallel_select, shift_clock_source_select} = 2'b11;
        step(6);
        check("oe_upper", data_oe_n[15:12], 4'hF);
        convert(16'h8001, 16'hFFFE);
        u_dacc_host_model.read_bits(8, word);
        {chip_select_n, read_n} = 2'b00;
        step(6);
        u_dacc_host_model.read_bits(32, word);
        check("serial_word", word, 32'h8001_FFFE);
        // Slow host caught mid-read by the next conversion
        u_dacc_host_model.half_ns = 300;
        u_dacc_host_model.read_bits(4, word);
        err_cnt = 0;
        convert(16'h1234, 16'h5678);
        check("read_error", err_cnt, 1);
        // Same overrun with the internal clock source raises nothing
        shift_clock_source_select = 1'b0;
        u_dacc_host_model.read_bits(4, word);
        err_cnt = 0;
        convert(16'h0F0F, 16'hF0F0);
        check("no_error", err_cnt, 0);
        {chip_select_n, read_n} = 2'b11;
        // Power-down during a conversion: it completes, later starts refused
        eoc_cnt = 0;
        kick();
        wait_busy(1'b1, n);
        power_down_request = 1'b1;
        wait_busy(1'b0, n);
        step(30);
        check("pd_eoc", eoc_cnt, 2);
        check("low_power", low_power, 1'b1);
        kick();
        step(30);
        check("pd_block", busy, 1'b0);
        power_down_request = 1'b0;
        step(5);
        // Reset pin in mid-conversion aborts at once
        eoc_cnt = 0;
        kick();
        wait_busy(1'b1, n);
        step(10);
        device_reset = 1'b1;
        step(8);
        check("abort_busy", busy, 1'b0);
        check("abort_eoc", eoc_cnt, 0);
        device_reset = 1'b0;
        step(30);
        check("idle_busy", busy, 1'b0);
        // Impulse mode: start held low restarts after acquisition
        impulse_mode = 1'b1;
        convert_start_n = 1'b0;
        wait_busy(1'b1, n);
        wait_busy(1'b0, n);
        wait_busy(1'b1, n);
        check("impulse_restart", (n <= 40), 1'b1);
        convert_start_n = 1'b1;
        wait_busy(1'b0, n);
        impulse_mode = 1'b0;
        step(30);
        // Result path through the queue: each new word replaces the last on the port
        serial_parallel_select = 1'b0;
        {chip_select_n, read_n} = 2'b00;
        for (int i = 1; i < 4; i++) begin
            convert(16'(i) * 16'h1111, ~(16'(i) * 16'h1111));
            check("path_data", data_out, 16'(i) * 16'h1111);
            check("path_oe", data_oe_n, 16'h0000);
        end
        check("path_busy", busy, 1'b0);
        check("path_error", err_cnt, 0);
        check("path_low_power", low_power, 1'b0);
        wrap_up();
    end
endmodule

// ---- verification/dacc_host_model.sv ----
// Host-side serial reader: drives the external shift clock, collects result bits.
// Assumes the bench owns chip select and read strobe and selects slave mode.
`timescale 1ns/1ns
module dacc_host_model #(
    parameter int HALF_NS = 62
) (
    // Serial pins
    output logic      ext_shift_clock,
    input  wire logic serial_result_out
);
    int half_ns = HALF_NS;

    // Clock rests low between frames; it never runs free
    initial ext_shift_clock = 1'b0;

    // Bit taken just before the rising edge that advances the shifter
    task automatic read_bits(input int n, output logic [31:0] word);
        word = '0;
        for (int i = 0; i < n; i++) begin
            #(half_ns + 1);
            word = {word[30:0], serial_result_out};
            ext_shift_clock = 1'b1;
            #(half_ns);
            ext_shift_clock = 1'b0;
        end
    endtask
endmodule
